// File: hw/nsl_pin_sync.sv
// nsl_pin_sync: two-flop synchronisers for the serial link pins
// assumes pins are asynchronous to clk_sys and reset is already synchronised
`timescale 1ns/100ps
module nsl_pin_sync
  import nsl_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rstnSync,
  input  wire logic                 ce,
  input  wire logic [PIN_COUNT-1:0] pinIn,
  input  wire logic [PIN_COUNT-1:0] pinIdle,
  output logic      [PIN_COUNT-1:0] pinSync
);

  logic [PIN_COUNT-1:0] pinMeta_reg;

  // ----------------------------------------------------------------
  // two stages; only the second stage is seen by the core
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      pinMeta_reg <= '1;  // all ones; idle level of chip select and write protect
      pinSync     <= '1;
    end
    else if (ce)
    begin
      pinMeta_reg <= pinIn;
      pinSync     <= pinMeta_reg;
    end
  end

  // pinIdle is kept for documentation of the reset level at the caller
  logic unusedIdle;
  assign unusedIdle = ^pinIdle;

endmodule

// File: hw/nsl_pkg.sv
// nsl_pkg: constants and types for the status, lock and protect block
// assumes a serial command link in mode 0 and a 2048-block array backend
package nsl_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WREN  = 8'h06;
  localparam logic [7:0] CMD_WRDI  = 8'h04;
  localparam logic [7:0] CMD_GETF  = 8'h0F;
  localparam logic [7:0] CMD_SETF  = 8'h1F;
  localparam logic [7:0] CMD_PROG  = 8'h10;
  localparam logic [7:0] CMD_PROT  = 8'h2A;
  localparam logic [7:0] CMD_ERASE = 8'hD8;

  // ----------------------------------------------------------------
  // feature addresses and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] FEAT_THRESH = 8'h10;
  localparam logic [7:0] FEAT_LOCK   = 8'hA0;
  localparam logic [7:0] FEAT_CONF   = 8'hB0;
  localparam logic [7:0] FEAT_STATUS = 8'hC0;
  localparam int THRESH_LSB      = 4;
  localparam int THRESH_MSB      = 7;
  localparam int LOCK_FREEZE_BIT = 7;
  localparam int LOCK_RANGE_LSB  = 3;
  localparam int LOCK_RANGE_MSB  = 5;
  localparam int PROTECT_ARM_BIT = 7;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] LOCK_NONE        = 3'h0;
  localparam logic [2:0] LOCK_ALL         = 3'h7;
  localparam logic [3:0] THRESH_RESET     = 4'h0;
  localparam logic [1:0] ECC_CLEAN        = 2'h0;
  localparam logic [1:0] ECC_CORR_LOW     = 2'h1;
  localparam logic [1:0] ECC_UNCORRECTED  = 2'h2;
  localparam logic [1:0] ECC_CORR_HIGH    = 2'h3;
  localparam logic [1:0] STATUS_RESERVED  = 2'h0;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int          BLOCK_W      = 11;
  localparam logic [11:0] BLOCK_COUNT  = 12'h800;
  localparam logic [10:0] PROT_FIRST   = 11'h780;
  localparam int          PROT_COUNT   = 128;
  localparam int          PROT_IDX_W   = 7;
  localparam int          BLOCK_LSB    = 6;
  localparam int          BLOCK_MSB    = 16;
  localparam logic [1:0]  ROW_LAST     = 2'h2;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam int          PIN_COUNT    = 4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OP_PROGRAM = 2'h0,
    OP_PROTECT = 2'h1,
    OP_ERASE   = 2'h2
  } nsl_op_t;

  // gray codes along command -> address -> data and command -> row
  typedef enum logic [2:0]
  {
    ST_CMD    = 3'h0,
    ST_ADDR   = 3'h1,
    ST_DATA   = 3'h3,
    ST_STREAM = 3'h2,
    ST_ROW    = 3'h4,
    ST_IGNORE = 3'h5
  } nsl_state_t;

endpackage

// File: hw/nsl_status_lock_protect.sv
// nsl_status_lock_protect: status byte, block lock and one-time block protect
// assumes a mode-0 serial host much slower than clk_sys, and an array backend
// on clk_sys that answers each opStart with one opDone pulse
//
// How it works
// RL1 - two-bit ecc result: clean, corrected low, uncorrectable, corrected at threshold
// RL2 - correction threshold comes from the upper nibble of feature 10h
// RL3 - program-fail bit set on failed program or protect, cleared on pass
// RL4 - erase-fail bit set on failed erase, cleared on pass
// RL5 - status bit 1 shows the write latch, zero after reset
// RL6 - only write-enable sets the write latch; write-disable clears it
// RL7 - status bit 0 shows busy while an operation runs
// RL8 - get-feature streams the addressed byte repeatedly until chip select rises
// RL9 - busy and fail bits are refreshed for every streamed byte
// RL10 - program, protect and erase on a locked block are refused
// RL11 - host selects the lock range through set-feature at address A0h
// RL12 - lock range resets to all locked
// RL13 - refused operation on a locked block raises program or erase fail
// RL14 - lock codes map to the upper fractions of 2048 blocks
// RL15 - lock freeze plus low write-protect pin blocks lock field writes
// RL16 - protected blocks always refuse program and erase
// RL17 - only blocks 1920 to 2047 can be protected
// RL18 - protect execute runs only while the arm bit at B0h is set
// RL19 - protection never reverts; host protects each block once
// RL20 - host arms protection, then write-enables, then sends protect execute
// RL21 - host polls status until ready, checks fail, then disarms
// RL22 - get-feature may be repeated any number of times
// RL23 - lock freeze is bit 7 of A0h, writable, reset to zero
// RL24 - write latch clears when a program, protect or erase finishes
`timescale 1ns/100ps
module nsl_status_lock_protect
  import nsl_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire logic                csN,
  input  wire logic                sclk,
  input  wire logic                si,
  input  wire logic                wpN,
  input  wire logic                opDone,
  input  wire logic                opFail,
  input  wire logic                readDone,
  input  wire logic [3:0]          readFlips,
  input  wire logic                readUncorr,
  output logic                     so,
  output logic                     soOe,
  output logic                     opStart,
  output nsl_op_t                  opKind,
  output logic      [BLOCK_W-1:0]  opBlock,
  output logic                     busyFlag
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstnSync;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta_reg <= 1'b0;
      rstnSync    <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstnSync    <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinSync;
  logic                 csNS;
  logic                 sclkS;
  logic                 siS;
  logic                 wpNS;
  logic                 sclkPrev_reg;
  logic                 csActive;
  logic                 sclkRise;
  logic                 sclkFall;

  nsl_pin_sync u_pin_sync
  (
    .clk_sys  (clk_sys),
    .rstnSync (rstnSync),
    .ce       (ce),
    .pinIn    ({csN, sclk, si, wpN}),
    .pinIdle  ({PIN_COUNT{1'b1}}),
    .pinSync  (pinSync)
  );

  assign csNS     = pinSync[3];
  assign sclkS    = pinSync[2];
  assign siS      = pinSync[1];
  assign wpNS     = pinSync[0];
  assign csActive = !csNS;
  assign sclkRise = csActive && sclkS && !sclkPrev_reg;
  assign sclkFall = csActive && !sclkS && sclkPrev_reg;

  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      sclkPrev_reg <= 1'b0;
    else if (ce)
      sclkPrev_reg <= sclkS;
  end

  // ----------------------------------------------------------------
  // feature and status storage
  // ----------------------------------------------------------------
  logic [3:0]            thresh_reg;
  logic                  lockFreeze_reg;
  logic [2:0]            lockRange_reg;
  logic                  protectArm_reg;
  logic [1:0]            eccStatus_reg;
  logic                  prgFail_reg;
  logic                  ersFail_reg;
  logic                  writeLatch_reg;
  logic [PROT_COUNT-1:0] protMask_reg;

  // read value of a feature address; status bits are taken live
  function automatic logic [7:0] featRead(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;  // unknown addresses and reserved bits read zero
    case (addr)
      FEAT_THRESH: val[THRESH_MSB:THRESH_LSB] = thresh_reg;
      FEAT_LOCK:
      begin
        val[LOCK_FREEZE_BIT]                = lockFreeze_reg;
        val[LOCK_RANGE_MSB:LOCK_RANGE_LSB]  = lockRange_reg;
      end
      FEAT_CONF:   val[PROTECT_ARM_BIT] = protectArm_reg;
      FEAT_STATUS: val = {STATUS_RESERVED, eccStatus_reg, prgFail_reg,
                          ersFail_reg, writeLatch_reg, busyFlag};  // RL5 RL7
      default:     val = 8'h00;
    endcase
    return val;
  endfunction

  // lock code 0 locks nothing, otherwise the top 2048>>(7-code) blocks
  function automatic logic blockLocked(input logic [2:0] code,
                                       input logic [BLOCK_W-1:0] blk);
    logic [11:0] first;
    first = BLOCK_COUNT - (BLOCK_COUNT >> (LOCK_ALL - code));  // RL14
    return (code != LOCK_NONE) && ({1'b0, blk} >= first);
  endfunction

  // ----------------------------------------------------------------
  // serial byte engine
  // ----------------------------------------------------------------
  nsl_state_t  state_reg;
  logic [2:0]  bitCnt_reg;
  logic [6:0]  rxShift_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  featAddr_reg;
  logic [1:0]  rowCnt_reg;
  logic [15:0] row_reg;
  logic [7:0]  outByte_reg;
  logic [2:0]  outIdx_reg;
  logic [7:0]  rxByte;
  logic        byteDone;

  assign rxByte   = {rxShift_reg, siS};
  assign byteDone = sclkRise && (bitCnt_reg == BIT_LAST);

  // bit counter and input shifter; chip select high restarts framing
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      bitCnt_reg  <= 3'h0;
      rxShift_reg <= 7'h00;
    end
    else if (ce)
    begin
      if (!csActive)
        bitCnt_reg <= 3'h0;
      else if (sclkRise)
      begin
        bitCnt_reg  <= bitCnt_reg + 3'h1;
        rxShift_reg <= rxByte[6:0];
      end
    end
  end

  // command state machine, one step per completed byte
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      state_reg    <= ST_CMD;
      cmd_reg      <= 8'h00;
      featAddr_reg <= 8'h00;
      rowCnt_reg   <= 2'h0;
      row_reg      <= 16'h0000;
    end
    else if (ce)
    begin
      if (!csActive)
        state_reg <= ST_CMD;
      else if (byteDone)
      begin
        case (state_reg)
          ST_CMD:
          begin
            cmd_reg    <= rxByte;
            rowCnt_reg <= 2'h0;
            if (rxByte == CMD_GETF || rxByte == CMD_SETF)
              state_reg <= ST_ADDR;
            else if (rxByte == CMD_PROG || rxByte == CMD_PROT || rxByte == CMD_ERASE)
              state_reg <= ST_ROW;
            else
              state_reg <= ST_IGNORE;
          end
          ST_ADDR:
          begin
            featAddr_reg <= rxByte;
            state_reg    <= (cmd_reg == CMD_GETF) ? ST_STREAM : ST_DATA;  // RL22
          end
          ST_DATA:   state_reg <= ST_IGNORE;
          ST_ROW:
          begin
            row_reg <= {row_reg[7:0], rxByte};
            if (rowCnt_reg == ROW_LAST)
              state_reg <= ST_IGNORE;
            else
              rowCnt_reg <= rowCnt_reg + 2'h1;
          end
          ST_STREAM: state_reg <= ST_STREAM;
          ST_IGNORE: state_reg <= ST_IGNORE;
          default:   state_reg <= ST_IGNORE;
        endcase
      end
    end
  end

  // output shifter: msb first on falling edges, byte reloaded at each end
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      outByte_reg <= 8'h00;
      outIdx_reg  <= BIT_LAST;
      so          <= 1'b0;
      soOe        <= 1'b0;
    end
    else if (ce)
    begin
      soOe <= csActive && (state_reg == ST_STREAM);  // released with chip select
      if (byteDone && state_reg == ST_ADDR)
      begin
        outByte_reg <= featRead(rxByte);  // RL8
        outIdx_reg  <= BIT_LAST;
      end
      else if (sclkFall && state_reg == ST_STREAM)
      begin
        so <= outByte_reg[outIdx_reg];
        if (outIdx_reg == 3'h0)
        begin
          outByte_reg <= featRead(featAddr_reg);  // RL8 RL9
          outIdx_reg  <= BIT_LAST;
        end
        else
          outIdx_reg <= outIdx_reg - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // decoded events
  // ----------------------------------------------------------------
  logic                wrenEvt;
  logic                wrdiEvt;
  logic                setfEvt;
  logic                execEvt;
  logic [23:0]         rowFull;
  logic [BLOCK_W-1:0]  execBlock;
  logic                execLocked;
  logic                execProt;
  logic                acceptOp;
  logic                rejectPrg;
  logic                rejectErs;
  nsl_op_t             execKind;

  assign wrenEvt   = byteDone && state_reg == ST_CMD && rxByte == CMD_WREN;  // RL6
  assign wrdiEvt   = byteDone && state_reg == ST_CMD && rxByte == CMD_WRDI;  // RL6
  assign setfEvt   = byteDone && state_reg == ST_DATA && cmd_reg == CMD_SETF;
  assign execEvt   = byteDone && state_reg == ST_ROW && rowCnt_reg == ROW_LAST;
  assign rowFull   = {row_reg, rxByte};
  assign execBlock = rowFull[BLOCK_MSB:BLOCK_LSB];
  assign execLocked = blockLocked(lockRange_reg, execBlock);
  assign execProt  = (execBlock >= PROT_FIRST) &&
                     protMask_reg[execBlock[PROT_IDX_W-1:0]];

  // refused operations never reach the array; lock, protect and range refusals set a fail bit and clear the write latch, an unarmed protect does neither
  always_comb
  begin
    acceptOp  = 1'b0;
    rejectPrg = 1'b0;
    rejectErs = 1'b0;
    execKind  = OP_PROGRAM;
    if (execEvt && !busyFlag && writeLatch_reg)
    begin
      case (cmd_reg)
        CMD_PROG:
        begin
          rejectPrg = execLocked || execProt;  // RL10 RL13 RL16
          acceptOp  = !rejectPrg;
        end
        CMD_ERASE:
        begin
          execKind  = OP_ERASE;
          rejectErs = execLocked || execProt;  // RL10 RL13 RL16
          acceptOp  = !rejectErs;
        end
        CMD_PROT:
        begin
          execKind = OP_PROTECT;
          if (protectArm_reg)  // RL18
          begin
            rejectPrg = execLocked || (execBlock < PROT_FIRST);  // RL10 RL17
            acceptOp  = !rejectPrg;
          end
        end
        default: acceptOp = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // operation launch and busy
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      opStart  <= 1'b0;
      opKind   <= OP_PROGRAM;
      opBlock  <= '0;
      busyFlag <= 1'b0;
    end
    else if (ce)
    begin
      opStart <= acceptOp;
      if (acceptOp)
      begin
        opKind   <= execKind;
        opBlock  <= execBlock;
        busyFlag <= 1'b1;  // RL7
      end
      else if (opDone)
        busyFlag <= 1'b0;  // RL7
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // a refusal and a completion cannot coincide: refusal needs ready
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      prgFail_reg <= 1'b0;
      ersFail_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (rejectPrg)
        prgFail_reg <= 1'b1;  // RL13
      else if (opDone && busyFlag && opKind != OP_ERASE)
        prgFail_reg <= opFail;  // RL3
      if (rejectErs)
        ersFail_reg <= 1'b1;  // RL13
      else if (opDone && busyFlag && opKind == OP_ERASE)
        ersFail_reg <= opFail;  // RL4
    end
  end

  // write latch: a fresh enable in the finishing cycle still wins
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      writeLatch_reg <= 1'b0;  // RL5
    else if (ce)
    begin
      if (wrenEvt)
        writeLatch_reg <= 1'b1;  // RL6
      else if (wrdiEvt || rejectPrg || rejectErs || (opDone && busyFlag))
        writeLatch_reg <= 1'b0;  // RL6 RL24
    end
  end

  // ecc outcome of the last page read
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      eccStatus_reg <= ECC_CLEAN;
    else if (ce && readDone)
    begin
      if (readUncorr)
        eccStatus_reg <= ECC_UNCORRECTED;  // RL1
      else if (readFlips == 4'h0)
        eccStatus_reg <= ECC_CLEAN;  // RL1
      else if (readFlips < thresh_reg)
        eccStatus_reg <= ECC_CORR_LOW;  // RL1 RL2
      else
        eccStatus_reg <= ECC_CORR_HIGH;  // RL1 RL2
    end
  end

  // ----------------------------------------------------------------
  // writable features
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
    begin
      thresh_reg     <= THRESH_RESET;
      lockFreeze_reg <= 1'b0;  // RL23
      lockRange_reg  <= LOCK_ALL;  // RL12
      protectArm_reg <= 1'b0;
    end
    else if (ce && setfEvt)
    begin
      case (featAddr_reg)
        FEAT_THRESH: thresh_reg <= rxByte[THRESH_MSB:THRESH_LSB];  // RL2
        FEAT_LOCK:
        begin
          if (!(lockFreeze_reg && !wpNS))  // RL15
          begin
            lockFreeze_reg <= rxByte[LOCK_FREEZE_BIT];  // RL23
            lockRange_reg  <= rxByte[LOCK_RANGE_MSB:LOCK_RANGE_LSB];
          end
        end
        FEAT_CONF:   protectArm_reg <= rxByte[PROTECT_ARM_BIT];  // RL18
        default:     protectArm_reg <= protectArm_reg;  // status is read-only
      endcase
    end
  end

  // ----------------------------------------------------------------
  // protected block map
  // ----------------------------------------------------------------
  // bits only ever set; reset stands in for the factory-blank state
  always_ff @(posedge clk_sys or negedge rstnSync)
  begin
    if (!rstnSync)
      protMask_reg <= '0;
    else if (ce && opDone && busyFlag && !opFail && opKind == OP_PROTECT)
      protMask_reg[opBlock[PROT_IDX_W-1:0]] <= 1'b1;  // RL17 RL19
  end

endmodule

// File: test/nsl_host_model.sv
// nsl_host_model: serial host driving chip select, clock and data in mode 0
// assumes clk_sys runs at 100 MHz; the link clock is 80 ns and idles low
`timescale 1ns/100ps
module nsl_host_model
(
  input  wire logic clk_sys,
  input  wire logic so,
  input  wire logic soOe,
  output logic      csN,
  output logic      sclk,
  output logic      si
);
  logic [7:0] rdByte [0:3];
  int         oeMiss;

  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    oeMiss = 0;
  end

  // ----------------------------------------------------------------
  // one frame: nb bytes out of tx (left aligned), then nrd bytes read
  // ----------------------------------------------------------------
  // si changes while sclk is low; so is sampled just before each rise
  task automatic frame(input logic [31:0] tx, input int nb, input int nrd);
    int i;
    csN = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (i = 0; i < (nb + nrd) * 8; i++)
    begin
      sclk = 1'b0;
      si = (i < nb * 8) ? tx[31 - i] : ~si; // don't-care bits keep toggling
      repeat (4) @(negedge clk_sys);
      if (i >= nb * 8)
      begin
        rdByte[(i - nb * 8) / 8][7 - (i % 8)] = so;
        if (soOe !== 1'b1)
          oeMiss++;
      end
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
    sclk = 1'b0;
    repeat (4) @(negedge clk_sys);
    csN = 1'b1;
    si = ~si; // released line shows no stale value
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// File: test/nsl_status_lock_protect_test.sv
// nsl_status_lock_protect_test: self-checking bench for status, lock and protect
// assumes the host model owns the serial pins and the bench plays the array backend
`timescale 1ns/100ps
module nsl_status_lock_protect_test
  import nsl_pkg::*;
;
  logic             clk_sys, rstn, wpN, opDone, opFail, readDone, readUncorr;
  logic [3:0]       readFlips;
  logic             csN, sclk, si, so, soOe, opStart, busyFlag;
  nsl_op_t          opKind, kindSeen;
  logic [10:0]      opBlock, blkSeen, b;
  int               errCount, checksDone, nStart, c;
  localparam logic [1:0] ECC_EXP [4] = '{ECC_CLEAN, ECC_CORR_LOW, ECC_CORR_HIGH, ECC_UNCORRECTED};

  nsl_status_lock_protect dut_u (.clk_sys(clk_sys), .rstn(rstn), .ce(1'b1), .csN(csN),
    .sclk(sclk), .si(si), .wpN(wpN), .opDone(opDone), .opFail(opFail), .readDone(readDone),
    .readFlips(readFlips), .readUncorr(readUncorr), .so(so), .soOe(soOe), .opStart(opStart),
    .opKind(opKind), .opBlock(opBlock), .busyFlag(busyFlag));
  nsl_host_model host_u (.clk_sys(clk_sys), .so(so), .soOe(soOe), .csN(csN), .sclk(sclk),
    .si(si));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // launches are caught here since they fall inside the exec frame
  always @(negedge clk_sys)
  begin
    if (opStart === 1'b1)
    begin
      nStart++;
      kindSeen = opKind;
      blkSeen = opBlock;
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e)
    begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finishTest();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // two streamed copies must both match
  task automatic gf(input logic [7:0] a, input logic [7:0] e);
    host_u.frame({CMD_GETF, a, 16'h0000}, 2, 2);
    chk("feature byte", {8'h00, e}, {8'h00, host_u.rdByte[0]});
    chk("repeat byte", {8'h00, e}, {8'h00, host_u.rdByte[1]});
  endtask

  task automatic sf(input logic [7:0] a, input logic [7:0] d);
    host_u.frame({CMD_SETF, a, d, 8'h00}, 3, 0);
  endtask

  task automatic ex(input logic [7:0] cm, input logic [10:0] bk, input logic go, input nsl_op_t k);
    int n0;
    host_u.frame({CMD_WREN, 24'h00_0000}, 1, 0);
    n0 = nStart;
    host_u.frame({cm, 7'h00, bk, 6'h00}, 4, 0);
    chk("start count", {15'h0000, go}, 16'(nStart - n0));
    if (go)
    begin
      chk("op kind", {14'h0000, k}, {14'h0000, kindSeen});
      chk("op block", {5'h00, bk}, {5'h00, blkSeen});
    end
  endtask

  // backend completion pulse, after a bounded wait for busy
  task automatic fin(input logic f);
    int i;
    for (i = 0; i < 40 && busyFlag !== 1'b1; i++)
      @(negedge clk_sys);
    if (i == 40)
    begin
      errCount++;
      finishTest();
    end
    opDone = 1'b1;
    opFail = f;
    @(negedge clk_sys);
    opDone = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    errCount = 0;
    checksDone = 0;
    nStart = 0;
    rstn = 1'b0;
    {wpN, opDone, opFail, readDone, readUncorr, readFlips} = 9'h100;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (6) @(negedge clk_sys);
    gf(FEAT_LOCK, 8'h38);
    gf(FEAT_CONF, 8'h00);
    sf(FEAT_STATUS, 8'h02);
    gf(FEAT_STATUS, 8'h00);
    host_u.frame({CMD_WREN, 24'h00_0000}, 1, 0);
    gf(FEAT_STATUS, 8'h02);
    host_u.frame({CMD_WRDI, 24'h00_0000}, 1, 0);
    gf(FEAT_STATUS, 8'h00);
    ex(CMD_PROG, 11'h005, 1'b0, OP_PROGRAM);
    gf(FEAT_STATUS, 8'h08);
    ex(CMD_ERASE, 11'h005, 1'b0, OP_ERASE);
    gf(FEAT_STATUS, 8'h0C);
    sf(FEAT_LOCK, 8'h00);
    ex(CMD_ERASE, 11'h003, 1'b1, OP_ERASE);
    // completion lands between the two streamed bytes
    fork
      host_u.frame({CMD_GETF, FEAT_STATUS, 16'h0000}, 2, 2);
      begin
        repeat (160) @(negedge clk_sys);
        fin(1'b0);
      end
    join
    chk("busy byte", 16'h000F, {8'h00, host_u.rdByte[0]});
    chk("live byte", 16'h0008, {8'h00, host_u.rdByte[1]});
    ex(CMD_PROG, 11'h3E8, 1'b1, OP_PROGRAM);
    fin(1'b1);
    gf(FEAT_STATUS, 8'h08);
    ex(CMD_ERASE, 11'h002, 1'b1, OP_ERASE);
    fin(1'b1);
    gf(FEAT_STATUS, 8'h0C);
    sf(FEAT_CONF, 8'h80);
    gf(FEAT_CONF, 8'h80);
    ex(CMD_PROT, 11'h77F, 1'b0, OP_PROTECT);
    ex(CMD_PROT, 11'h7FF, 1'b1, OP_PROTECT);
    fin(1'b0);
    gf(FEAT_STATUS, 8'h04);
    sf(FEAT_CONF, 8'h00);
    ex(CMD_PROG, 11'h7FF, 1'b0, OP_PROGRAM);
    gf(FEAT_STATUS, 8'h0C);
    ex(CMD_PROT, 11'h7D0, 1'b0, OP_PROTECT);
    gf(FEAT_STATUS, 8'h0E);
    for (c = 1; c < 7; c++)
    begin
      sf(FEAT_LOCK, 8'(c << 3));
      b = 11'(2048 - (2048 >> (7 - c)));
      ex(CMD_ERASE, b - 11'h001, 1'b1, OP_ERASE);
      fin(1'b0);
      ex(CMD_ERASE, b, 1'b0, OP_ERASE);
    end
    sf(FEAT_LOCK, 8'h80);
    wpN = 1'b0;
    sf(FEAT_LOCK, 8'h38);
    gf(FEAT_LOCK, 8'h80);
    wpN = 1'b1;
    sf(FEAT_LOCK, 8'h08);
    gf(FEAT_LOCK, 8'h08);
    sf(FEAT_THRESH, 8'h30);
    gf(FEAT_THRESH, 8'h30);
    for (c = 0; c < 4; c++)
    begin
      readFlips = 4'(c + (c > 0));
      readUncorr = (c == 3);
      readDone = 1'b1;
      @(negedge clk_sys);
      readDone = 1'b0;
      gf(FEAT_STATUS, {2'b00, ECC_EXP[c], 4'hC});
    end
    chk("output enable", 16'h0000, 16'(host_u.oeMiss));
    finishTest();
  end
endmodule

// File: test/nsl_sva.sv
// nsl_sva: port checker for the status, lock and protect block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module nsl_sva
  import nsl_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               ce,
  input wire logic               csN,
  input wire logic               opDone,
  input wire logic               soOe,
  input wire logic               opStart,
  input wire nsl_op_t            opKind,
  input wire logic [BLOCK_W-1:0] opBlock,
  input wire logic               busyFlag
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // busy, launch and output enable
  // ----------------------------------------------------------------
  start_sets_busy_a: assert property (opStart |-> busyFlag)
    else $error("busy not raised with start");
  busy_held_a: assert property (busyFlag && !(opDone && ce) |=> busyFlag)
    else $error("busy dropped without completion");
  busy_clear_a: assert property (busyFlag && opDone && ce |=> !busyFlag)
    else $error("busy stuck after completion");
  idle_start_a: assert property (opStart |-> !$past(busyFlag))
    else $error("start while busy");
  start_pulse_a: assert property (opStart |=> !opStart)
    else $error("start longer than one cycle");
  op_stable_a: assert property (busyFlag && !opStart |-> $stable(opKind) && $stable(opBlock))
    else $error("operation changed while busy");
  protect_range_a: assert property (opStart && opKind == OP_PROTECT |-> opBlock >= PROT_FIRST)
    else $error("protect launched below range");
  oe_cs_a: assert property (csN [*6] |-> !soOe)
    else $error("output driven while deselected");

  cover property (opStart && opKind == OP_PROTECT);
  cover property (busyFlag && opDone);
  cover property ($rose(soOe));
endmodule

bind nsl_status_lock_protect nsl_sva chk_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
  .csN(csN), .opDone(opDone), .soOe(soOe), .opStart(opStart), .opKind(opKind),
  .opBlock(opBlock), .busyFlag(busyFlag));
